// ---- verilog/two_wire_write_pkg.sv ----
// Constants and types for the two-wire write slave front end
package two_wire_write_pkg;
	// Device address word layout
	localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int CS_HIGH_POS = 3;
	localparam int CS_LOW_POS = 2;
	localparam int PAGE_SEL_POS = 1;
	localparam int RW_POS = 0;
	// Memory address layout
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int ROW_W = 9;
	localparam int ROW_LSB = 8;
	// Bit counter values
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [3:0] CNT_AT_START_SEEN = 4'h3;
	localparam logic [3:0] CNT_LAST_BIT = 4'h7;
	localparam logic [3:0] CNT_ACK = 4'h8;
	// Write cycle timing
	localparam int PROG_CYCLE_TIME_MS = 5;
	localparam int MCLK_HZ = 125000000;
	localparam int PROG_CYCLE_CNT = PROG_CYCLE_TIME_MS * (MCLK_HZ / 1000);

	typedef enum logic [4:0] {
		L_IDLE = 5'h01,
		L_DEV = 5'h02,
		L_HI = 5'h04,
		L_LO = 5'h08,
		L_DATA = 5'h10
	} link_st_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} load_t;

	typedef struct packed {
		logic start;
		logic busy;
		logic [ROW_W-1:0] row;
	} prog_t;

	typedef struct packed {
		link_st_t st;
		logic [3:0] cnt;
		logic [DATA_W-1:0] shreg;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W+DATA_W-1:0] word;
		logic data_tgl;
		logic nack_tgl;
		logic ack_due;
		logic st_s1;
		logic st_s2;
		logic st_d;
		logic busy_s1;
		logic busy_s2;
		logic [1:0] cs_s1;
		logic [1:0] cs_s2;
		logic rst_s1;
		logic rst_s2;
	} link_state_t;

	typedef struct packed {
		logic oe;
	} link_drive_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic wp_s1;
		logic wp_s2;
		logic dt_s1;
		logic dt_s2;
		logic dt_d;
		logic nk_s1;
		logic nk_s2;
		logic nk_d;
		logic start_tgl;
		logic frame;
		logic pending;
		logic standby;
		logic [31:0] cnt;
		prog_t prog;
		load_t load;
	} core_state_t;
endpackage

// ---- verilog/two_wire_eeprom_write_slave.sv ----
// Two-wire slave front end: address decode, write path, write cycle timer
// How it works
// - Falling data with clock high starts
// - Rising data with clock high stops
// - Data changes only while clock low
// - Ack low in ninth clock per byte
// - Standby at reset, and after stop once no write cycle runs
// - Start, nine clocks, start, stop resets
// - Address word upper nibble must match
// - Chip-select bits must equal strap pins
// - Page-select bit is address MSB
// - Last address bit selects read/write
// - Match acks; mismatch stays silent, standby
// - Write-protect high blocks all writes
// - Address: page bit, high, low byte
// - Ack bytes; stop starts programming
// - Write cycle ends within 5 ms
// - No ack while write cycle runs
// - Page write up to 256 bytes
// - Only low address byte increments
// - Address wraps within the same page
// - Poll acks only after write done
// - Data line driven only low
// - 512 pages of 256 bytes
`timescale 1ns/10ps
module two_wire_eeprom_write_slave #(
	parameter int unsigned PROG_CYCLES = two_wire_write_pkg::PROG_CYCLE_CNT
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic chip_select_bit_low_i,
	input wire logic chip_select_bit_high_i,
	input wire logic write_protect_i,
	output two_wire_write_pkg::load_t load_o,
	output two_wire_write_pkg::prog_t prog_o,
	output logic standby_o
);
	generate
		// Start check needs three busy cycles after the stop
		if (PROG_CYCLES < 3) begin : g_bad_prog
			$error("PROG_CYCLES must be at least 3");
		end
	endgenerate

	function automatic logic dev_match(input logic [7:0] b,
		input logic [1:0] cs);
		dev_match = (b[two_wire_write_pkg::TYPE_MSB:
			two_wire_write_pkg::TYPE_LSB] ==
			two_wire_write_pkg::DEV_TYPE_CODE) &&
			(b[two_wire_write_pkg::CS_HIGH_POS] == cs[1]) &&
			(b[two_wire_write_pkg::CS_LOW_POS] == cs[0]);
	endfunction

	two_wire_write_pkg::core_state_t core;
	two_wire_write_pkg::core_state_t next_core;
	two_wire_write_pkg::link_state_t link;
	two_wire_write_pkg::link_state_t next_link;
	two_wire_write_pkg::link_drive_t drv;
	two_wire_write_pkg::link_drive_t next_drv;

	logic start_det;
	logic stop_det;
	logic dt_evt;
	logic nk_evt;
	logic new_start;
	logic byte_done;
	logic [7:0] rx_byte;

	// Link side: bits taken on the rising serial clock
	assign rx_byte = {link.shreg[6:0], sda_i};
	assign new_start = link.st_s2 != link.st_d;
	assign byte_done = !new_start && link.cnt == two_wire_write_pkg::CNT_LAST_BIT;

	always_comb begin
		next_link = link;
		next_link.rst_s1 = reset_n_i;
		next_link.rst_s2 = link.rst_s1;
		next_link.st_s1 = core.start_tgl;
		next_link.st_s2 = link.st_s1;
		next_link.st_d = link.st_s2;
		next_link.busy_s1 = core.prog.busy;
		next_link.busy_s2 = link.busy_s1;
		next_link.cs_s1 = {chip_select_bit_high_i, chip_select_bit_low_i};
		next_link.cs_s2 = link.cs_s1;
		next_link.shreg = rx_byte;
		next_link.ack_due = 1'b0;
		// Start is seen two rises late; the shifted history keeps those bits
		if (new_start) begin
			next_link.st = two_wire_write_pkg::L_DEV;
			next_link.cnt = two_wire_write_pkg::CNT_AT_START_SEEN;
		end else if (link.cnt == two_wire_write_pkg::CNT_ACK) begin
			next_link.cnt = two_wire_write_pkg::CNT_RESET;
		end else begin
			next_link.cnt = link.cnt + 4'h1;
		end
		if (byte_done) begin
			unique case (link.st)
				two_wire_write_pkg::L_IDLE: begin
				end
				two_wire_write_pkg::L_DEV: begin
					// Busy or foreign address: silent, drop to idle
					if (dev_match(rx_byte, link.cs_s2) && !link.busy_s2) begin
						next_link.ack_due = 1'b1;
						next_link.addr[two_wire_write_pkg::ADDR_W-1] =
							rx_byte[two_wire_write_pkg::PAGE_SEL_POS];
						// Reads are served elsewhere; this end only acks them
						next_link.st = rx_byte[two_wire_write_pkg::RW_POS] ?
							two_wire_write_pkg::L_IDLE :
							two_wire_write_pkg::L_HI;
					end else begin
						next_link.st = two_wire_write_pkg::L_IDLE;
						next_link.nack_tgl = !link.nack_tgl;
					end
				end
				two_wire_write_pkg::L_HI: begin
					next_link.addr[15:8] = rx_byte;
					next_link.ack_due = 1'b1;
					next_link.st = two_wire_write_pkg::L_LO;
				end
				two_wire_write_pkg::L_LO: begin
					next_link.addr[7:0] = rx_byte;
					next_link.ack_due = 1'b1;
					next_link.st = two_wire_write_pkg::L_DATA;
				end
				two_wire_write_pkg::L_DATA: begin
					next_link.word = {link.addr, rx_byte};
					next_link.data_tgl = !link.data_tgl;
					next_link.ack_due = 1'b1;
					next_link.addr[7:0] = link.addr[7:0] + 8'h01;
				end
				default: begin
					next_link.st = two_wire_write_pkg::L_IDLE;
				end
			endcase
		end
		if (!link.rst_s2) begin
			next_link.st = two_wire_write_pkg::L_IDLE;
			next_link.cnt = two_wire_write_pkg::CNT_RESET;
			next_link.shreg = 8'h00;
			next_link.addr = 17'h00000;
			next_link.word = 25'h0000000;
			next_link.data_tgl = 1'b0;
			next_link.nack_tgl = 1'b0;
			next_link.ack_due = 1'b0;
			next_link.st_s1 = 1'b0;
			next_link.st_s2 = 1'b0;
			next_link.st_d = 1'b0;
		end
	end

	always_ff @(posedge scl_i) begin
		link <= next_link;
	end

	// Drive changes on the falling clock so it never forms a start or stop
	always_comb begin
		next_drv.oe = link.ack_due && link.rst_s2;
	end

	always_ff @(negedge scl_i) begin
		drv <= next_drv;
	end

	// Frame gate also keeps the pin released before the link is initialised
	assign sda_o = 1'b0;
	assign sda_oe_o = drv.oe && core.frame;

	// System side: conditions seen on synchronised pins
	assign start_det = core.scl_s2 && core.scl_d && core.sda_d && !core.sda_s2;
	assign stop_det = core.scl_s2 && core.scl_d && !core.sda_d && core.sda_s2;
	assign dt_evt = core.dt_s2 != core.dt_d;
	assign nk_evt = core.nk_s2 != core.nk_d;

	always_comb begin
		next_core = core;
		next_core.scl_s1 = scl_i;
		next_core.scl_s2 = core.scl_s1;
		next_core.scl_d = core.scl_s2;
		next_core.sda_s1 = sda_i;
		next_core.sda_s2 = core.sda_s1;
		next_core.sda_d = core.sda_s2;
		next_core.wp_s1 = write_protect_i;
		next_core.wp_s2 = core.wp_s1;
		next_core.dt_s1 = link.data_tgl;
		next_core.dt_s2 = core.dt_s1;
		next_core.dt_d = core.dt_s2;
		next_core.nk_s1 = link.nack_tgl;
		next_core.nk_s2 = core.nk_s1;
		next_core.nk_d = core.nk_s2;
		next_core.load.valid = 1'b0;
		next_core.prog.start = 1'b0;
		if (core.prog.busy) begin
			if (core.cnt == 32'h0) begin
				next_core.prog.busy = 1'b0;
			end else begin
				next_core.cnt = core.cnt - 32'h1;
			end
		end
		if (start_det) begin
			next_core.start_tgl = !core.start_tgl;
			next_core.frame = 1'b1;
			// A repeated start abandons bytes not closed by a stop
			next_core.pending = 1'b0;
		end
		if (stop_det) begin
			next_core.frame = 1'b0;
			next_core.pending = 1'b0;
			if (core.pending && !core.wp_s2 && !core.prog.busy) begin
				next_core.prog.start = 1'b1;
				next_core.prog.busy = 1'b1;
				next_core.prog.row = core.load.addr[two_wire_write_pkg::ADDR_W-1:
					two_wire_write_pkg::ROW_LSB];
				next_core.cnt = 32'(PROG_CYCLES - 1);
			end
		end
		if (nk_evt) begin
			next_core.frame = 1'b0;
		end
		// Word is held stable by the link until the next byte ends
		if (dt_evt && !core.wp_s2) begin
			next_core.load.valid = 1'b1;
			next_core.load.addr = link.word[24:8];
			next_core.load.data = link.word[7:0];
			next_core.pending = 1'b1;
		end
		next_core.standby = !next_core.frame && !next_core.prog.busy;
		if (!reset_n_i) begin
			next_core = '0;
			next_core.scl_s1 = 1'b1;
			next_core.scl_s2 = 1'b1;
			next_core.scl_d = 1'b1;
			next_core.sda_s1 = 1'b1;
			next_core.sda_s2 = 1'b1;
			next_core.sda_d = 1'b1;
			next_core.standby = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		core <= next_core;
	end

	assign load_o = core.load;
	assign prog_o = core.prog;
	assign standby_o = core.standby;

	// Assertion helper: length of the current write cycle
	logic [31:0] busy_run;
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i || core.prog.start) begin
			busy_run <= 32'h1;
		end else if (core.prog.busy) begin
			busy_run <= busy_run + 32'h1;
		end
	end

	sequence s_stop_with_work;
		stop_det && core.pending && !core.wp_s2 && !core.prog.busy;
	endsequence

	sequence s_prog_begin;
		core.prog.start ##1 (core.prog.busy && !core.prog.start) [*2];
	endsequence

	property p_start_frame;
		@(posedge mclk_i) disable iff (!reset_n_i)
		start_det |=> core.frame && !core.standby;
	endproperty
	a_start_frame: assert property (p_start_frame)
		else $error("start did not open a frame");

	property p_stop_frame;
		@(posedge mclk_i) disable iff (!reset_n_i)
		stop_det && !start_det |=> !core.frame;
	endproperty
	a_stop_frame: assert property (p_stop_frame)
		else $error("stop did not close the frame");

	property p_prog_on_stop;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_stop_with_work |=> s_prog_begin;
	endproperty
	a_prog_on_stop: assert property (p_prog_on_stop)
		else $error("stop after data did not start programming");

	property p_wp_no_prog;
		@(posedge mclk_i) disable iff (!reset_n_i)
		core.wp_s2 |=> !core.prog.start;
	endproperty
	a_wp_no_prog: assert property (p_wp_no_prog)
		else $error("programming started while protected");

	property p_wp_no_load;
		@(posedge mclk_i) disable iff (!reset_n_i)
		dt_evt && core.wp_s2 |=> !core.load.valid &&
			(!core.pending || $past(core.pending));
	endproperty
	a_wp_no_load: assert property (p_wp_no_load)
		else $error("byte loaded while protected");

	property p_load_byte;
		@(posedge mclk_i) disable iff (!reset_n_i)
		dt_evt && !core.wp_s2 |=> core.load.valid ##1 !core.load.valid;
	endproperty
	a_load_byte: assert property (p_load_byte)
		else $error("received byte not loaded once");

	property p_busy_len;
		@(posedge mclk_i) disable iff (!reset_n_i)
		$fell(core.prog.busy) |-> busy_run == PROG_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("write cycle length wrong");

	property p_standby_after_stop;
		@(posedge mclk_i) disable iff (!reset_n_i)
		stop_det && !core.pending && !core.prog.busy && !start_det
			|=> core.standby;
	endproperty
	a_standby_after_stop: assert property (p_standby_after_stop)
		else $error("no standby after idle stop");

	property p_no_ack_busy;
		@(posedge scl_i) disable iff (!link.rst_s2)
		byte_done && link.st == two_wire_write_pkg::L_DEV && link.busy_s2
			|=> !link.ack_due;
	endproperty
	a_no_ack_busy: assert property (p_no_ack_busy)
		else $error("acknowledged during write cycle");

	property p_no_ack_foreign;
		@(posedge scl_i) disable iff (!link.rst_s2)
		byte_done && link.st == two_wire_write_pkg::L_DEV &&
			!dev_match(rx_byte, link.cs_s2)
			|=> !link.ack_due && link.st == two_wire_write_pkg::L_IDLE;
	endproperty
	a_no_ack_foreign: assert property (p_no_ack_foreign)
		else $error("acknowledged a foreign address");

	property p_ack_slot;
		@(posedge scl_i) disable iff (!link.rst_s2)
		link.ack_due |-> link.cnt == two_wire_write_pkg::CNT_ACK;
	endproperty
	a_ack_slot: assert property (p_ack_slot)
		else $error("acknowledge outside the ninth clock");

	property p_page_wrap;
		@(posedge scl_i) disable iff (!link.rst_s2)
		byte_done && link.st == two_wire_write_pkg::L_DATA |=>
			link.addr[16:8] == $past(link.addr[16:8]) &&
			link.addr[7:0] == $past(link.addr[7:0]) + 8'h01;
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("address left its page");

	property p_busy_bound;
		@(posedge mclk_i) disable iff (!reset_n_i)
		core.prog.busy |-> busy_run <= PROG_CYCLES;
	endproperty
	a_busy_bound: assert property (p_busy_bound)
		else $error("write cycle ran too long");

	property p_page_bit;
		@(posedge scl_i) disable iff (!link.rst_s2)
		byte_done && link.st == two_wire_write_pkg::L_DEV &&
			dev_match(rx_byte, link.cs_s2) && !link.busy_s2
			|=> link.ack_due &&
			link.addr[two_wire_write_pkg::ADDR_W-1] ==
			$past(rx_byte[two_wire_write_pkg::PAGE_SEL_POS]);
	endproperty
	a_page_bit: assert property (p_page_bit)
		else $error("page bit not taken as address top bit");

	property p_addr_high;
		@(posedge scl_i) disable iff (!link.rst_s2)
		byte_done && link.st == two_wire_write_pkg::L_HI |=>
			link.addr[15:8] == $past(rx_byte) &&
			link.st == two_wire_write_pkg::L_LO;
	endproperty
	a_addr_high: assert property (p_addr_high)
		else $error("high address byte not taken");
endmodule

// ---- verif/two_wire_master.sv ----
// Behavioural two-wire bus master driving clock and data
`timescale 1ns/10ps
module two_wire_master (
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	localparam time Q = 40ns;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Clock with data high, so no start is formed
	task automatic idle_clocks(input int n);
		repeat (n) begin
			#(2*Q) scl_o = 1'b0;
			#(2*Q) scl_o = 1'b1;
		end
	endtask
	task automatic start();
		if (!scl_o) begin
			#Q sda_o = 1'b1;
			#Q scl_o = 1'b1;
		end
		#(2*Q) sda_o = 1'b0;
		#(2*Q) scl_o = 1'b0;
	endtask
	task automatic stop();
		#Q sda_o = 1'b0;
		#Q scl_o = 1'b1;
		#(2*Q) sda_o = 1'b1;
		#(2*Q);
	endtask
	// Data moves only in the low half of the clock
	task automatic bit_out(input logic b, output logic got);
		#Q sda_o = b;
		#Q scl_o = 1'b1;
		got = sda_i;
		#(2*Q) scl_o = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_out(b[i], g);
		bit_out(1'b1, g);
		ack = !g;
	endtask
endmodule

// ---- verif/two_wire_eeprom_write_slave_bench.sv ----
// Self-checking bench for the two-wire write slave front end
`timescale 1ns/10ps
module two_wire_eeprom_write_slave_bench;
	localparam int unsigned PROG = 400;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic cs_lo = 1'b0;
	logic cs_hi = 1'b1;
	logic wp = 1'b0;
	logic scl, msda, sda_out, sda_oe, standby;
	wire logic sda_w;
	two_wire_write_pkg::load_t load;
	two_wire_write_pkg::prog_t prog;
	two_wire_write_pkg::load_t loads[$];
	int err_total = 0;
	int comparisons = 0;
	int starts = 0;
	int busy_n = 0;
	int ticks = 0;
	always #4 mclk = ~mclk;
	// Pull-up holds the wire high unless the master or the device pulls
	assign sda_w = msda & (sda_oe ? sda_out : 1'b1);
	two_wire_eeprom_write_slave #(.PROG_CYCLES(PROG)) dut (
		.mclk_i(mclk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_out), .sda_oe_o(sda_oe), .chip_select_bit_low_i(cs_lo),
		.chip_select_bit_high_i(cs_hi), .write_protect_i(wp),
		.load_o(load), .prog_o(prog), .standby_o(standby));
	two_wire_master master (.scl_o(scl), .sda_o(msda), .sda_i(sda_w));
	always @(posedge mclk) begin
		ticks++;
		if (load.valid === 1'b1)
			loads.push_back(load);
		if (prog.start === 1'b1)
			starts++;
		if (prog.busy === 1'b1)
			busy_n++;
		// Whole run needs about 7100 cycles
		if (ticks == 30000) begin
			err_total++;
			$display("[FAIL] %0t timeout", $time);
			close_out();
		end
	end
	task automatic close_out();
		$display("Compares %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic fail(input string m);
		err_total++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic check_bit(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp)
			fail(m);
	endtask
	task automatic check_cnt(input int got, input int exp, input string m);
		comparisons++;
		if (got != exp)
			fail(m);
	endtask
	task automatic check_load(input two_wire_write_pkg::load_t got,
		input two_wire_write_pkg::load_t exp);
		comparisons++;
		if (got !== exp)
			fail("load");
	endtask
	function automatic logic [7:0] dev(input logic pg, input logic rw);
		return {two_wire_write_pkg::DEV_TYPE_CODE, cs_hi, cs_lo, pg, rw};
	endfunction
	task automatic settle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic clear();
		starts = 0;
		busy_n = 0;
		loads.delete();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < PROG + 40 && prog.busy !== 1'b0; i++)
			@(negedge mclk);
	endtask
	task automatic send(input logic [7:0] b, input logic exp);
		logic a;
		master.put_byte(b, a);
		check_bit(a, exp, "ack");
	endtask
	task automatic head(input logic [16:0] ad);
		master.start();
		send(dev(ad[16], 1'b0), 1'b1);
		send(ad[15:8], 1'b1);
		send(ad[7:0], 1'b1);
	endtask
	task automatic data(input int n, input logic [7:0] seed);
		for (int i = 0; i < n; i++)
			send(seed + i[7:0], 1'b1);
	endtask
	task automatic expect_loads(input logic [16:0] ad, input int n,
		input logic [7:0] seed);
		check_cnt(loads.size(), n, "load count");
		for (int i = 0; i < n && loads.size() > 0; i++)
			check_load(loads.pop_front(), {1'b1, ad[16:8], ad[7:0] + i[7:0],
				seed + i[7:0]});
	endtask
	// Scan clocks during reset so the link domain sees it
	task automatic t_reset();
		master.idle_clocks(4);
		check_bit(standby, 1'b1, "standby in reset");
		check_bit(sda_oe, 1'b0, "drive in reset");
		check_bit(sda_out, 1'b0, "drive level");
		@(negedge mclk);
		reset_n = 1'b1;
		// Link reset clears only after two serial clock rises
		master.idle_clocks(2);
		check_bit(standby, 1'b1, "standby after reset");
	endtask
	task automatic t_mismatch();
		logic [7:0] bad[3];
		bad = '{{4'hb, cs_hi, cs_lo, 2'b00}, {4'ha, ~cs_hi, cs_lo, 2'b00},
			{4'ha, cs_hi, ~cs_lo, 2'b00}};
		foreach (bad[i]) begin
			master.start();
			send(bad[i], 1'b0);
			settle(8);
			check_bit(standby, 1'b1, "standby after miss");
			master.stop();
		end
		@(negedge mclk);
		cs_lo = 1'b1;
		cs_hi = 1'b0;
		master.start();
		send(dev(1'b0, 1'b1), 1'b1);
		master.stop();
	endtask
	task automatic t_byte();
		clear();
		head(17'h1_2345);
		data(1, 8'h5a);
		check_bit(standby, 1'b0, "standby in frame");
		master.stop();
		check_bit(prog.busy, 1'b1, "busy after stop");
		check_bit(prog.row === 9'h123, 1'b1, "row");
		master.start();
		send(dev(1'b0, 1'b0), 1'b0);
		master.stop();
		wait_idle();
		check_cnt(busy_n, int'(PROG), "busy length");
		check_cnt(starts, 1, "one program");
		check_bit(standby, 1'b1, "standby after write");
		master.start();
		send(dev(1'b0, 1'b0), 1'b1);
		master.stop();
		expect_loads(17'h1_2345, 1, 8'h5a);
	endtask
	// Low byte starts near the end so the wrap is crossed
	task automatic t_page();
		clear();
		head(17'h0_fffd);
		data(5, 8'h10);
		master.stop();
		check_bit(prog.row === 9'h0ff, 1'b1, "row kept");
		wait_idle();
		expect_loads(17'h0_fffd, 5, 8'h10);
	endtask
	task automatic t_protect();
		@(negedge mclk);
		wp = 1'b1;
		settle(2);
		clear();
		head(17'h0_0100);
		data(2, 8'h33);
		master.stop();
		settle(20);
		check_cnt(loads.size(), 0, "protected load");
		check_cnt(starts, 0, "protected program");
		@(negedge mclk);
		wp = 1'b0;
	endtask
	task automatic t_soft();
		logic a;
		clear();
		master.start();
		send(dev(1'b0, 1'b0), 1'b1);
		send(8'h02, 1'b1);
		master.put_byte(8'hff, a);
		master.start();
		master.stop();
		settle(20);
		check_cnt(starts, 0, "program after reset");
		head(17'h0_0207);
		data(1, 8'hc3);
		master.stop();
		wait_idle();
		expect_loads(17'h0_0207, 1, 8'hc3);
		check_cnt(starts, 1, "program after soft");
	endtask
	initial begin
		t_reset();
		t_mismatch();
		t_byte();
		t_page();
		t_protect();
		t_soft();
		close_out();
	end
endmodule
